// ### src/bpio_edge_detect.sv
`timescale 1ns/1ps
module bpio_edge_detect #(
  parameter int W = 8
) (
  input  wire logic     clk_sys,
  input  wire logic     reset,
  bpio_edge_if.detector ep
);

  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] fall_r;

  // two-stage synchroniser, idle high so reset gives no false edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r  <= '1;
    end else begin
      sync1_r <= ep.level;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // high-to-low compare on synchronised levels only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fall_r <= '0;
    end else begin
      fall_r <= prev_r & ~sync2_r;
    end
  end

  assign ep.fall = fall_r;

endmodule : bpio_edge_detect

// ### src/bpio_edge_if.sv
`timescale 1ns/1ps
interface bpio_edge_if #(parameter int W = 8);
  logic [W-1:0] level;  // raw pin levels, asynchronous to clk_sys
  logic [W-1:0] fall;   // one-cycle high-to-low pulse per pin

  modport detector (input level, output fall);
  modport user     (output level, input fall);
endinterface : bpio_edge_if

// ### src/bpio_pkg.sv
package bpio_pkg;

  // port numbering inside the block: a, c, d, e, f
  localparam int          NPORT        = 5;
  localparam int          PW           = 8;
  localparam int          PORT_C       = 1;

  // register byte offsets on the bus
  localparam logic [7:0]  PORT_A_DATA_OFS = 8'h00;
  localparam logic [7:0]  PORT_A_DIR_OFS  = 8'h04;
  localparam logic [7:0]  PORT_STRIDE     = 8'h08;
  localparam logic [7:0]  PIN_IRQ_OFS     = 8'h28;
  localparam logic [7:0]  WAKE_EN_OFS     = 8'h2C;
  localparam logic [7:0]  POWER_DOWN_OFS  = 8'h30;
  localparam logic [7:0]  IRQ_STATUS_OFS  = 8'h34;
  localparam logic [7:0]  IRQ_MASK_OFS    = 8'h38;
  localparam logic [7:0]  BIT_MODIFY_OFS  = 8'h3C;

  // reset values
  localparam logic [7:0]  PORT_RST     = 8'hFF;
  localparam logic [7:0]  WAKE_EN_RST  = 8'h00;
  localparam logic [2:0]  PIN_IRQ_RST  = 3'h0;
  localparam logic [1:0]  IRQ_RST      = 2'h0;

  // open-drain lines of port c have no direction bit
  localparam logic [7:0]  PC_OD_MASK   = 8'h0C;

  // pin interrupt register fields
  localparam int          PIRQ_EN_LSB    = 0;
  localparam int          PIRQ_CAUSE_LSB = 4;
  localparam int          NPIRQ          = 3;
  // port c pin numbers of the three interrupt sources
  localparam int          PIRQ_PIN0      = 0;
  localparam int          PIRQ_PIN1      = 5;
  localparam int          PIRQ_PIN2      = 7;

  // status bits
  localparam int          ST_WAKE      = 0;
  localparam int          ST_PIRQ      = 1;

  // bit modify command fields
  localparam int          BM_BIT_LSB   = 0;
  localparam int          BM_TGT_LSB   = 4;
  localparam int          BM_VAL_BIT   = 8;

endpackage : bpio_pkg

// ### src/bpio_port_top.sv
`timescale 1ns/1ps
module bpio_port_top (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // classic wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // pins, index 0..4 = ports a, c, d, e, f
  input  wire logic [4:0][7:0]       pad_in,
  output logic      [4:0][7:0]       pad_out,
  output logic      [4:0][7:0]       pad_oe,
  input  wire logic [4:0][7:0]       pullup_option,
  output logic      [4:0][7:0]       pullup_en,
  // core power-down and interrupt
  output logic                       core_halt,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int NP = bpio_pkg::NPORT;

  logic [NP-1:0][7:0] data_r;       // output latches
  logic [NP-1:0][7:0] dir_r;        // direction, 1 = input
  logic [NP-1:0][7:0] dir_eff;      // direction with unimplemented bits
  logic [NP-1:0][7:0] port_rd;      // value a port read returns
  logic [7:0]         wake_en_r;
  logic [2:0]         pirq_en_r;
  logic [2:0]         pirq_cause_r;
  logic [1:0]         irq_sts_r;
  logic [1:0]         irq_mask_r;
  logic               halt_r;
  logic               ack_r;
  logic [31:0]        rdat_r;
  logic               irq_r;
  logic [NP-1:0][7:0] pout_r;
  logic [NP-1:0][7:0] poe_r;
  logic [NP-1:0][7:0] pull_r;

  logic               acc;          // new bus request this cycle
  logic               wr;           // register write strobe
  logic [7:0]         adr;
  logic [7:0]         wd;
  logic               wake_evt;
  logic [2:0]         pirq_set;
  logic               bm_hit;
  logic [3:0]         bm_tgt;
  logic [2:0]         bm_bit;
  logic               bm_val;
  logic [7:0]         bm_base;
  logic [7:0]         bm_new;
  logic [31:0]        rd_mux;

  bpio_edge_if #(.W(8)) wake_ep ();
  bpio_edge_if #(.W(3)) pirq_ep ();

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // take a request once; the answer flop blocks a second take
  assign acc    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr     = acc & wb_we_i & wb_sel_i[0];
  assign adr    = {wb_adr_i[7:2], 2'b00};
  assign wd     = wb_dat_i[7:0];

  // bit modify command: target 0..4 data, 5..9 direction
  assign bm_hit = wr & (adr == bpio_pkg::BIT_MODIFY_OFS);
  assign bm_bit = wb_dat_i[bpio_pkg::BM_BIT_LSB +: 3];
  assign bm_tgt = wb_dat_i[bpio_pkg::BM_TGT_LSB +: 4];
  assign bm_val = wb_dat_i[bpio_pkg::BM_VAL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // port read values

  // port c open-drain lines always act as outputs
  generate
    for (genvar p = 0; p < NP; p++) begin : g_rd
      if (p == bpio_pkg::PORT_C) begin : g_c
        assign dir_eff[p] = dir_r[p] & ~bpio_pkg::PC_OD_MASK;
      end else begin : g_o
        assign dir_eff[p] = dir_r[p];
      end
      // inputs read live pins, outputs read the latch
      assign port_rd[p] = (dir_eff[p] & pad_in[p])
                        | (~dir_eff[p] & data_r[p]);
    end
  endgenerate

  // read-modify-write base: whole port as read, then one bit changed
  always_comb begin
    bm_base = 8'h00;
    if (bm_tgt < 4'(NP)) begin
      bm_base = port_rd[bm_tgt[2:0]];
    end else if (bm_tgt < 4'(2 * NP)) begin
      bm_base = dir_eff[3'(bm_tgt - 4'(NP))];
    end
    bm_new         = bm_base;
    bm_new[bm_bit] = bm_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data and direction registers

  generate
    for (genvar p = 0; p < NP; p++) begin : g_reg
      localparam logic [7:0] DOFS = 8'(bpio_pkg::PORT_A_DATA_OFS
                                       + p * bpio_pkg::PORT_STRIDE);
      localparam logic [7:0] COFS = 8'(bpio_pkg::PORT_A_DIR_OFS
                                       + p * bpio_pkg::PORT_STRIDE);
      // output latch holds until the next data write
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          data_r[p] <= bpio_pkg::PORT_RST;
        end else if (wr & (adr == DOFS)) begin
          data_r[p] <= wd;
        end else if (bm_hit & (bm_tgt == 4'(p))) begin
          data_r[p] <= bm_new;
        end
      end
      // direction takes effect on the write, no other sequence
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          dir_r[p] <= bpio_pkg::PORT_RST;
        end else if (wr & (adr == COFS)) begin
          dir_r[p] <= wd;
        end else if (bm_hit & (bm_tgt == 4'(p + NP))) begin
          dir_r[p] <= bm_new;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  generate
    for (genvar p = 0; p < NP; p++) begin : g_pin
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          pout_r[p] <= 8'h00;
          poe_r[p]  <= 8'h00;
          pull_r[p] <= 8'h00;
        end else begin
          pout_r[p] <= data_r[p];
          poe_r[p]  <= ~dir_eff[p];
          pull_r[p] <= pullup_option[p] & dir_eff[p];
          if (p == bpio_pkg::PORT_C) begin
            // open-drain: drive low only, never pulled up
            pout_r[p] <= data_r[p] & ~bpio_pkg::PC_OD_MASK;
            poe_r[p]  <= (~dir_eff[p] & ~bpio_pkg::PC_OD_MASK)
                       | (~data_r[p] & bpio_pkg::PC_OD_MASK);
            pull_r[p] <= pullup_option[p] & dir_eff[p];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on wake and pin interrupt sources

  assign wake_ep.level = pad_in[0];
  assign pirq_ep.level = {pad_in[bpio_pkg::PORT_C][bpio_pkg::PIRQ_PIN2],
                          pad_in[bpio_pkg::PORT_C][bpio_pkg::PIRQ_PIN1],
                          pad_in[bpio_pkg::PORT_C][bpio_pkg::PIRQ_PIN0]};

  bpio_edge_detect #(.W(8)) u_wake_edge (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ep      (wake_ep)
  );

  bpio_edge_detect #(.W(3)) u_pirq_edge (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ep      (pirq_ep)
  );

  // any selected port a falling edge while halted wakes the core
  assign wake_evt = halt_r & |(wake_ep.fall & wake_en_r);
  assign pirq_set = pirq_ep.fall & pirq_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // wake-up and power-down

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_en_r <= bpio_pkg::WAKE_EN_RST;
    end else if (wr & (adr == bpio_pkg::WAKE_EN_OFS)) begin
      wake_en_r <= wd;
    end
  end

  // halt holds until a wake edge; a wake beats a new halt request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      halt_r <= 1'b0;
    end else if (wake_evt) begin
      halt_r <= 1'b0;
    end else if (wr & (adr == bpio_pkg::POWER_DOWN_OFS) & wd[0]) begin
      halt_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin interrupt enable and cause

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pirq_en_r <= bpio_pkg::PIN_IRQ_RST;
    end else if (wr & (adr == bpio_pkg::PIN_IRQ_OFS)) begin
      pirq_en_r <= wd[bpio_pkg::PIRQ_EN_LSB +: 3];
    end
  end

  // cause bits: written 0 clears, a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pirq_cause_r <= bpio_pkg::PIN_IRQ_RST;
    end else if (wr & (adr == bpio_pkg::PIN_IRQ_OFS)) begin
      pirq_cause_r <= (pirq_cause_r & wd[bpio_pkg::PIRQ_CAUSE_LSB +: 3])
                    | pirq_set;
    end else begin
      pirq_cause_r <= pirq_cause_r | pirq_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_sts_r <= bpio_pkg::IRQ_RST;
    end else begin
      irq_sts_r[bpio_pkg::ST_WAKE] <= wake_evt |
        (irq_sts_r[bpio_pkg::ST_WAKE] &
         ~(wr & (adr == bpio_pkg::IRQ_STATUS_OFS) & wd[bpio_pkg::ST_WAKE]));
      irq_sts_r[bpio_pkg::ST_PIRQ] <= (|pirq_set) |
        (irq_sts_r[bpio_pkg::ST_PIRQ] &
         ~(wr & (adr == bpio_pkg::IRQ_STATUS_OFS) & wd[bpio_pkg::ST_PIRQ]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_mask_r <= bpio_pkg::IRQ_RST;
    end else if (wr & (adr == bpio_pkg::IRQ_MASK_OFS)) begin
      irq_mask_r <= wd[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_sts_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and answer

  // pins are sampled in the cycle the request is taken
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int p = 0; p < NP; p++) begin
      if (adr == 8'(bpio_pkg::PORT_A_DATA_OFS + p * bpio_pkg::PORT_STRIDE))
      begin
        rd_mux = {24'h00_0000, port_rd[p]};
      end
      if (adr == 8'(bpio_pkg::PORT_A_DIR_OFS + p * bpio_pkg::PORT_STRIDE))
      begin
        rd_mux = {24'h00_0000, dir_eff[p]};
      end
    end
    case (adr)
      bpio_pkg::PIN_IRQ_OFS:    rd_mux = {25'h000_0000, pirq_cause_r,
                                          1'b0, pirq_en_r};
      bpio_pkg::WAKE_EN_OFS:    rd_mux = {24'h00_0000, wake_en_r};
      bpio_pkg::POWER_DOWN_OFS: rd_mux = {31'h0000_0000, halt_r};
      bpio_pkg::IRQ_STATUS_OFS: rd_mux = {30'h0000_0000, irq_sts_r};
      bpio_pkg::IRQ_MASK_OFS:   rd_mux = {30'h0000_0000, irq_mask_r};
      default:                  rd_mux = rd_mux;
    endcase
  end

  // one answer per request, dropped in the following cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= acc;
      if (acc & ~wb_we_i) begin
        rdat_r <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = rdat_r;
  assign pad_out   = pout_r;
  assign pad_oe    = poe_r;
  assign pullup_en = pull_r;
  assign core_halt = halt_r;
  assign irq       = irq_r;

endmodule : bpio_port_top

// ### test/bpio_pin_model.sv
`timescale 1ns/1ps
module bpio_pin_model (
  input  wire logic            clk_sys,
  input  wire logic [4:0][7:0] pad_out,
  input  wire logic [4:0][7:0] pad_oe,
  input  wire logic [4:0][7:0] pullup_en,
  input  wire logic [4:0][7:0] sw_level,
  input  wire logic [4:0][7:0] sw_on,
  output logic      [4:0][7:0] pad_in
);
  logic [4:0][7:0] float_r = '0;
  // an open, unpulled pin wanders every cycle
  always @(posedge clk_sys) begin
    float_r <= ~float_r;
  end
  // wire level: block drive, else switch, else pull-up or float
  assign pad_in = (pad_oe & pad_out)
    | (~pad_oe & sw_on & sw_level)
    | (~pad_oe & ~sw_on & (pullup_en | float_r));
endmodule : bpio_pin_model

// ### test/bpio_port_monitor.sv
`timescale 1ns/1ps
module bpio_port_monitor (
  input wire logic            clk_sys,
  input wire logic            reset,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [3:0]      wb_sel_i,
  input wire logic [31:0]     wb_dat_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [4:0][7:0] pad_in,
  input wire logic [4:0][7:0] pad_out,
  input wire logic [4:0][7:0] pad_oe,
  input wire logic [4:0][7:0] pullup_option,
  input wire logic [4:0][7:0] pullup_en,
  input wire logic            core_halt,
  input wire logic            irq
);
  logic take;
  logic wr;
  logic rd_a;
  // bus request taken, byte write, port a data read
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr   = take & wb_we_i & wb_sel_i[0];
  assign rd_a = take & ~wb_we_i & (wb_adr_i == bpio_pkg::PORT_A_DATA_OFS);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  ack_one_cycle_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one cycle answer");
  oe_from_dir_a: assert property (
    wr && wb_adr_i == bpio_pkg::PORT_A_DIR_OFS |-> ##2
    pad_oe[0] == ~$past(wb_dat_i[7:0], 2))
    else $error("port a enables do not follow direction write");
  od_line_low_a: assert property (
    pad_out[1][3:2] == 2'h0 && pullup_en[1][3:2] == 2'h0)
    else $error("open drain line driven high or pulled up");
  pullup_input_a: assert property (
    (pullup_en & pad_oe) == '0 && (pullup_en & ~pullup_option) == '0)
    else $error("pull-up on an output or without option");
  out_latched_a: assert property (
    $changed(pad_out) |-> $past(wr, 2) || $past(reset, 3))
    else $error("pin drive changed without a write");
  halt_entry_a: assert property (
    wr && wb_adr_i == bpio_pkg::POWER_DOWN_OFS && wb_dat_i[0]
    |=> core_halt)
    else $error("power-down write did not halt");
  wake_by_fall_a: assert property (
    $fell(core_halt) |-> ($past(pad_in[0], 5) & ~$past(pad_in[0], 4)) != '0)
    else $error("halt ended without a port a falling edge");
  read_pins_a: assert property (
    rd_a |=> ((wb_dat_o[7:0] ^ $past(pad_in[0])) & ~pad_oe[0]) == '0)
    else $error("input bits do not show pin levels");
  read_latch_a: assert property (
    rd_a |=> ((wb_dat_o[7:0] ^ pad_out[0]) & pad_oe[0]) == '0)
    else $error("output bits do not show the latch");
  unmapped_zero_a: assert property (
    take && !wb_we_i && wb_adr_i > 8'h3F |=> wb_dat_o == '0)
    else $error("unmapped read not zero");
  // main scenarios reached
  cover property ($fell(core_halt));
  cover property ($rose(irq));
  cover property (rd_a ##1 wb_ack_o);
endmodule : bpio_port_monitor

bind bpio_port_top bpio_port_monitor u_mon (.clk_sys, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .pad_in, .pad_out, .pad_oe, .pullup_option, .pullup_en,
  .core_halt, .irq);

// ### test/test_bidir_port_io_with_wakeup.sv
`timescale 1ns/1ps
module test_bidir_port_io_with_wakeup;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic [7:0]  exp;
  } bpio_row_type;
  logic                 clk_sys, reset, core_halt, irq;
  logic                 wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]           wb_adr_i;
  logic [3:0]           wb_sel_i;
  logic [31:0]          wb_dat_i, wb_dat_o, rd;
  logic [4:0][7:0]      pad_in, pad_out, pad_oe, pullup_option, pullup_en;
  logic [4:0][7:0]      sw_level, sw_on;
  int                   err_count, num_checks, cycles;
  // we, address, write data, byte enables, expected read
  bpio_row_type rows [17] = '{
    '{1'b0, 8'h04, 32'h000, 4'hF, 8'hFF},
    '{1'b0, 8'h0C, 32'h000, 4'hF, 8'hF3},
    '{1'b0, 8'h00, 32'h000, 4'hF, 8'hC3},
    '{1'b1, 8'h04, 32'h00F, 4'hF, 8'h00},
    '{1'b1, 8'h00, 32'h05A, 4'hF, 8'h00},
    '{1'b0, 8'h00, 32'h000, 4'hF, 8'h53},
    '{1'b1, 8'h00, 32'h000, 4'h0, 8'h00},
    '{1'b0, 8'h00, 32'h000, 4'hF, 8'h53},
    '{1'b1, 8'h3C, 32'h157, 4'hF, 8'h00},
    '{1'b0, 8'h04, 32'h000, 4'hF, 8'h8F},
    '{1'b0, 8'h00, 32'h000, 4'hF, 8'hD3},
    '{1'b1, 8'h3C, 32'h000, 4'hF, 8'h00},
    '{1'b1, 8'h04, 32'h000, 4'hF, 8'h00},
    '{1'b0, 8'h00, 32'h000, 4'hF, 8'hD2},
    '{1'b0, 8'h40, 32'h000, 4'hF, 8'h00},
    '{1'b1, 8'h38, 32'h003, 4'hF, 8'h00},
    '{1'b1, 8'h08, 32'h000, 4'hF, 8'h00}};
  bpio_port_top uut (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pad_in,
    .pad_out, .pad_oe, .pullup_option, .pullup_en, .core_halt, .irq);
  bpio_pin_model pins (.clk_sys, .pad_out, .pad_oe, .pullup_en,
    .sw_level, .sw_on, .pad_in);
  // compare and count
  task automatic chk(input string name, input logic [39:0] seen,
                     input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, input logic [3:0] sel);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {adr, dat, sel};
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_sys);
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wb(1'b1, adr, {24'h0, dat}, 4'hF);
  endtask : wr
  task automatic rdc(input string name, input logic [7:0] adr,
                     input logic [7:0] exp);
    wb(1'b0, adr, 32'h0, 4'hF);
    chk(name, rd, exp);
  endtask : rdc
  task automatic summarize;
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end
  // main sequence
  initial begin
    {err_count, num_checks, cycles} = '0;
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    pullup_option = {5{8'hA5}};
    sw_level = {5{8'hC3}};
    sw_on = {5{8'hFF}};
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("enables", pad_oe, '0);
    chk("a out", pad_out[0], 8'hFF);
    chk("c out", pad_out[1], 8'hF3);
    chk("pullups", pullup_en[1:0], 16'hA1A5);
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat, rows[i].sel);
      if (!rows[i].we) chk($sformatf("row %0d", i), rd, rows[i].exp);
    end
    chk("a enables", pad_oe[0], 8'hFF);
    chk("a out", pad_out[0], 8'hD2);
    chk("a pullups", pullup_en[0], 8'h00);
    chk("c enables", pad_oe[1], 8'h0C);
    wr(8'h04, 8'hFF);
    sw_level[0] <= 8'hFF;
    wr(8'h2C, 8'h06);
    wr(8'h30, 8'h01);
    chk("halt", core_halt, 1'b1);
    sw_level[0] <= 8'hFE;
    repeat (8) @(posedge clk_sys);
    chk("halt kept", core_halt, 1'b1);
    sw_level[0] <= 8'hFA;
    repeat (8) @(posedge clk_sys);
    chk("woken", core_halt, 1'b0);
    rdc("status", 8'h34, 8'h01);
    chk("irq", irq, 1'b1);
    wr(8'h34, 8'h01);
    chk("irq clear", irq, 1'b0);
    sw_level[1] <= 8'hFF;
    wr(8'h28, 8'h02);
    sw_level[1] <= 8'hFE;
    repeat (6) @(posedge clk_sys);
    sw_level[1] <= 8'hDE;
    repeat (6) @(posedge clk_sys);
    rdc("cause", 8'h28, 8'h22);
    rdc("status", 8'h34, 8'h02);
    wr(8'h38, 8'h01);
    chk("masked", irq, 1'b0);
    wr(8'h28, 8'h02);
    rdc("cause clr", 8'h28, 8'h02);
    wr(8'h34, 8'h02);
    wr(8'h38, 8'h03);
    chk("irq off", irq, 1'b0);
    // reset in mid-run brings every register back to its start value
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("reset halt irq", {core_halt, irq}, 2'b00);
    chk("reset a out", pad_out[0], 8'hFF);
    rdc("reset a dir", 8'h04, 8'hFF);
    rdc("reset c data", 8'h08, 8'hDE);
    rdc("reset mask", 8'h38, 8'h00);
    summarize();
  end
endmodule : test_bidir_port_io_with_wakeup
